// >>> rtl/hpp_pkg.sv
package hpp_pkg;
   // Register page that holds every high-port register
   localparam logic [7:0] PAGE_HIGH     = 8'h0F;
   // Output latch offsets
   localparam logic [7:0] ADDR_LATCH4   = 8'hC8;
   localparam logic [7:0] ADDR_LATCH5   = 8'hD8;
   localparam logic [7:0] ADDR_LATCH6   = 8'hE8;
   localparam logic [7:0] ADDR_LATCH7   = 8'hF8;
   // Drive-mode offsets
   localparam logic [7:0] ADDR_MODE4    = 8'h9C;
   localparam logic [7:0] ADDR_MODE5    = 8'h9D;
   localparam logic [7:0] ADDR_MODE6    = 8'h9E;
   localparam logic [7:0] ADDR_MODE7    = 8'h9F;
   // Reset values
   localparam logic [7:0] LATCH_RST     = 8'hFF;
   localparam logic [7:0] MODE_RST      = 8'h00;
   // Port 4 carries only its upper three pins
   localparam int         P4_LSB        = 5;
   localparam int         P4_W          = 3;
   localparam int         PORT_W        = 8;
   // Reserved low bits of port 4 latch read back as ones
   localparam logic [4:0] P4_RSVD_RD    = 5'h1F;
   // Synchroniser depth on the pin read path
   localparam int         SYNC_STAGES   = 2;
   // Total synchronised pin count: 3 + 8 + 8 + 8
   localparam int         PIN_W         = 27;
endpackage : hpp_pkg

// >>> rtl/hpp_sync.sv
`timescale 1ns/1ps
// Two-flop level synchroniser; the first stage feeds only the second
module hpp_sync #(
   parameter int W = 8
) (
   input  wire logic         core_clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   // First stage may go metastable, so nothing else reads it
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : hpp_sync

// >>> rtl/hpp_port.sv
`timescale 1ns/1ps
// How it works
// - push-pull: latch 0 drives low, 1 high
// - open-drain: latch 0 drives low, 1 floats
// - drive-mode bit 0 open-drain, 1 push-pull
// - reset clears all drive-mode bits
// - pull-ups on; global disable turns all off
// - pull-up off on any pin driven low
// - memory interface overrides latches during access
// - drive modes kept; reads release data bus
// - data register write updates output latch
// - data register read returns pin levels
// - port 4 has only bits 7 to 5
// - port 4 pins carry strobes and ALE
// - port 5 is address high, non-multiplexed
// - port 6 address high muxed, low otherwise
// - read-modify-write reads return latch contents
// - port 7 is address/data or data byte
module hpp_port (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  sfr_page,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic        sfr_rmw,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   output logic             sfr_hit,
   input  wire logic        pullup_global_disable,
   input  wire logic        external_memory_interface_en,
   input  wire logic        external_memory_interface_active,
   input  wire logic        external_memory_interface_read,
   input  wire logic        external_memory_interface_muxed,
   input  wire logic        external_memory_interface_wr_n,
   input  wire logic        external_memory_interface_rd_n,
   input  wire logic        external_memory_interface_ale,
   input  wire logic [15:0] external_memory_interface_addr,
   input  wire logic [7:0]  external_memory_interface_wdata,
   input  wire logic [2:0]  p4_pin_in,
   output logic      [2:0]  p4_pin_out,
   output logic      [2:0]  p4_pin_oe,
   output logic      [2:0]  p4_pullup_en,
   input  wire logic [7:0]  p5_pin_in,
   output logic      [7:0]  p5_pin_out,
   output logic      [7:0]  p5_pin_oe,
   output logic      [7:0]  p5_pullup_en,
   input  wire logic [7:0]  p6_pin_in,
   output logic      [7:0]  p6_pin_out,
   output logic      [7:0]  p6_pin_oe,
   output logic      [7:0]  p6_pullup_en,
   input  wire logic [7:0]  p7_pin_in,
   output logic      [7:0]  p7_pin_out,
   output logic      [7:0]  p7_pin_oe,
   output logic      [7:0]  p7_pullup_en
);
   logic [7:0] port4_output_latch;
   logic [7:0] port5_output_latch;
   logic [7:0] port6_output_latch;
   logic [7:0] port7_output_latch;
   logic [2:0] port4_drive_mode;
   logic [7:0] port5_drive_mode;
   logic [7:0] port6_drive_mode;
   logic [7:0] port7_drive_mode;
   logic [hpp_pkg::PIN_W-1:0] pin_sync;
   logic [2:0] p4_lvl;
   logic [7:0] p5_lvl;
   logic [7:0] p6_lvl;
   logic [7:0] p7_lvl;
   logic       external_memory_interface_on;
   logic       p7_addr_phase;
   logic       p7_float;
   logic [2:0] p4_val;
   logic [7:0] p5_val;
   logic [7:0] p6_val;
   logic [7:0] p7_val;
   logic [2:0] p4_oe_nxt;
   logic [7:0] p5_oe_nxt;
   logic [7:0] p6_oe_nxt;
   logic [7:0] p7_oe_nxt;
   logic [7:0] p4_oe_w;
   logic [7:0] p4_pu_w;
   logic [7:0] rdata_nxt;

   // Access decode: only the high-port page reaches these registers
   function automatic logic acc(input logic [7:0] page,
                                input logic [7:0] addr,
                                input logic [7:0] offs);
      acc = (page == hpp_pkg::PAGE_HIGH) && (addr == offs);
   endfunction : acc

   // Output enable: a 0 is always driven, a 1 only in push-pull
   function automatic logic [7:0] drv_oe(input logic [7:0] val,
                                         input logic [7:0] mode);
      drv_oe = ~val | mode;
   endfunction : drv_oe

   // Pull-up stays off wherever the pin is being driven low
   function automatic logic [7:0] pu_en(input logic [7:0] val,
                                        input logic [7:0] oe,
                                        input logic       dis);
      pu_en = {8{~dis}} & ~(oe & ~val);
   endfunction : pu_en

   assign sfr_hit = acc(sfr_page, sfr_addr, hpp_pkg::ADDR_LATCH4) |
                    acc(sfr_page, sfr_addr, hpp_pkg::ADDR_LATCH5) |
                    acc(sfr_page, sfr_addr, hpp_pkg::ADDR_LATCH6) |
                    acc(sfr_page, sfr_addr, hpp_pkg::ADDR_LATCH7) |
                    acc(sfr_page, sfr_addr, hpp_pkg::ADDR_MODE4)  |
                    acc(sfr_page, sfr_addr, hpp_pkg::ADDR_MODE5)  |
                    acc(sfr_page, sfr_addr, hpp_pkg::ADDR_MODE6)  |
                    acc(sfr_page, sfr_addr, hpp_pkg::ADDR_MODE7);

   // Output latches; port 4 keeps only its top three bits
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         port4_output_latch <= hpp_pkg::LATCH_RST;
         port5_output_latch <= hpp_pkg::LATCH_RST;
         port6_output_latch <= hpp_pkg::LATCH_RST;
         port7_output_latch <= hpp_pkg::LATCH_RST;
      end else if (sfr_wr) begin
         if (acc(sfr_page, sfr_addr, hpp_pkg::ADDR_LATCH4)) begin
            port4_output_latch <= {sfr_wdata[7:5], 5'h1F};
         end
         if (acc(sfr_page, sfr_addr, hpp_pkg::ADDR_LATCH5)) begin
            port5_output_latch <= sfr_wdata;
         end
         if (acc(sfr_page, sfr_addr, hpp_pkg::ADDR_LATCH6)) begin
            port6_output_latch <= sfr_wdata;
         end
         if (acc(sfr_page, sfr_addr, hpp_pkg::ADDR_LATCH7)) begin
            port7_output_latch <= sfr_wdata;
         end
      end
   end

   // Drive-mode registers, all open-drain out of reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         port4_drive_mode <= hpp_pkg::MODE_RST[7:5];
         port5_drive_mode <= hpp_pkg::MODE_RST;
         port6_drive_mode <= hpp_pkg::MODE_RST;
         port7_drive_mode <= hpp_pkg::MODE_RST;
      end else if (sfr_wr) begin
         if (acc(sfr_page, sfr_addr, hpp_pkg::ADDR_MODE4)) begin
            port4_drive_mode <= sfr_wdata[7:5];
         end
         if (acc(sfr_page, sfr_addr, hpp_pkg::ADDR_MODE5)) begin
            port5_drive_mode <= sfr_wdata;
         end
         if (acc(sfr_page, sfr_addr, hpp_pkg::ADDR_MODE6)) begin
            port6_drive_mode <= sfr_wdata;
         end
         if (acc(sfr_page, sfr_addr, hpp_pkg::ADDR_MODE7)) begin
            port7_drive_mode <= sfr_wdata;
         end
      end
   end

   // Pin levels are asynchronous to the core, so they are synchronised
   hpp_sync #(
      .W (hpp_pkg::PIN_W)
   ) u_sync (
      .core_clk (core_clk),
      .rstn     (rstn),
      .d        ({p4_pin_in, p5_pin_in, p6_pin_in, p7_pin_in}),
      .q        (pin_sync)
   );
   assign p4_lvl = pin_sync[26:24];
   assign p5_lvl = pin_sync[23:16];
   assign p6_lvl = pin_sync[15:8];
   assign p7_lvl = pin_sync[7:0];

   // Memory interface takes over pin values, never the drive modes
   assign external_memory_interface_on       = external_memory_interface_en & external_memory_interface_active;
   assign p7_addr_phase = external_memory_interface_muxed & external_memory_interface_ale;
   assign p7_float      = external_memory_interface_on & external_memory_interface_read & ~p7_addr_phase;
   assign p4_val = external_memory_interface_on ? {external_memory_interface_wr_n, external_memory_interface_rd_n, external_memory_interface_ale}
                           : port4_output_latch[7:5];
   assign p5_val = (external_memory_interface_on & ~external_memory_interface_muxed) ? external_memory_interface_addr[15:8]
                                           : port5_output_latch;
   assign p6_val = !external_memory_interface_on  ? port6_output_latch
                 : external_memory_interface_muxed ? external_memory_interface_addr[15:8]
                              : external_memory_interface_addr[7:0];
   assign p7_val = !external_memory_interface_on     ? port7_output_latch
                 : p7_addr_phase ? external_memory_interface_addr[7:0]
                                 : external_memory_interface_wdata;

   // Enables follow mode; data bus released during off-chip reads
   always_comb begin
      p4_oe_w   = drv_oe({p4_val, 5'h00}, {port4_drive_mode, 5'h00});
      p4_oe_nxt = p4_oe_w[7:5];
      p5_oe_nxt = drv_oe(p5_val, port5_drive_mode);
      p6_oe_nxt = drv_oe(p6_val, port6_drive_mode);
      p7_oe_nxt = p7_float ? 8'h00
                           : drv_oe(p7_val, port7_drive_mode);
   end

   // Pin outputs are registered to keep glitches off the pads
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         p4_pin_out <= 3'h7;
         p5_pin_out <= 8'hFF;
         p6_pin_out <= 8'hFF;
         p7_pin_out <= 8'hFF;
         p4_pin_oe  <= 3'h0;
         p5_pin_oe  <= 8'h00;
         p6_pin_oe  <= 8'h00;
         p7_pin_oe  <= 8'h00;
      end else begin
         p4_pin_out <= p4_val;
         p5_pin_out <= p5_val;
         p6_pin_out <= p6_val;
         p7_pin_out <= p7_val;
         p4_pin_oe  <= p4_oe_nxt;
         p5_pin_oe  <= p5_oe_nxt;
         p6_pin_oe  <= p6_oe_nxt;
         p7_pin_oe  <= p7_oe_nxt;
      end
   end

   // Port 4 goes through the byte-wide helpers; only its top pins are kept
   assign p4_pu_w = pu_en({p4_val, 5'h1F}, {p4_oe_nxt, 5'h00},
                          pullup_global_disable);

   // Weak pull-ups, cut globally or where the pin pulls low
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         p4_pullup_en <= 3'h7;
         p5_pullup_en <= 8'hFF;
         p6_pullup_en <= 8'hFF;
         p7_pullup_en <= 8'hFF;
      end else begin
         p4_pullup_en <= p4_pu_w[7:5];
         p5_pullup_en <= pu_en(p5_val, p5_oe_nxt,
                               pullup_global_disable);
         p6_pullup_en <= pu_en(p6_val, p6_oe_nxt,
                               pullup_global_disable);
         p7_pullup_en <= pu_en(p7_val, p7_oe_nxt,
                               pullup_global_disable);
      end
   end

   // Read mux: pins normally, latches for read-modify-write
   always_comb begin
      rdata_nxt = 8'h00;
      if (acc(sfr_page, sfr_addr, hpp_pkg::ADDR_LATCH4)) begin
         rdata_nxt = sfr_rmw ? port4_output_latch
                             : {p4_lvl, hpp_pkg::P4_RSVD_RD};
      end else if (acc(sfr_page, sfr_addr, hpp_pkg::ADDR_LATCH5)) begin
         rdata_nxt = sfr_rmw ? port5_output_latch : p5_lvl;
      end else if (acc(sfr_page, sfr_addr, hpp_pkg::ADDR_LATCH6)) begin
         rdata_nxt = sfr_rmw ? port6_output_latch : p6_lvl;
      end else if (acc(sfr_page, sfr_addr, hpp_pkg::ADDR_LATCH7)) begin
         rdata_nxt = sfr_rmw ? port7_output_latch : p7_lvl;
      end else if (acc(sfr_page, sfr_addr, hpp_pkg::ADDR_MODE4)) begin
         rdata_nxt = {port4_drive_mode, 5'h00};
      end else if (acc(sfr_page, sfr_addr, hpp_pkg::ADDR_MODE5)) begin
         rdata_nxt = port5_drive_mode;
      end else if (acc(sfr_page, sfr_addr, hpp_pkg::ADDR_MODE6)) begin
         rdata_nxt = port6_drive_mode;
      end else if (acc(sfr_page, sfr_addr, hpp_pkg::ADDR_MODE7)) begin
         rdata_nxt = port7_drive_mode;
      end
   end

   // Read data held until the next read; misses return zero
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         sfr_rdata <= rdata_nxt;
      end
   end

   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!rstn);

   pp_high_a: assert property (
      ##1 ((p6_pin_oe & p6_pin_out) & ~$past(port6_drive_mode)) == 8'h00)
      else $error("Open-drain pin driven high on port 6");
   od_float_a: assert property (
      (!external_memory_interface_on && port5_drive_mode == 8'h00 && port5_output_latch == 8'hFF)
      |=> p5_pin_oe == 8'h00)
      else $error("Open-drain latch one not released on port 5");
   mode_write_a: assert property (
      (sfr_wr && acc(sfr_page, sfr_addr, hpp_pkg::ADDR_MODE6))
      |=> port6_drive_mode == $past(sfr_wdata) ##1
          p6_pin_oe == drv_oe($past(p6_val), $past(port6_drive_mode)))
      else $error("Drive-mode write not applied to port 6");
   pu_disable_a: assert property (
      pullup_global_disable |=> (p5_pullup_en | p6_pullup_en
                                 | p7_pullup_en) == 8'h00)
      else $error("Pull-up left on under global disable");
   pu_contend_a: assert property (
      (p7_pullup_en & p7_pin_oe & ~p7_pin_out) == 8'h00)
      else $error("Pull-up fights a low-driven pin");
   external_memory_interface_strobe_a: assert property (
      external_memory_interface_on |=> p4_pin_out == $past({external_memory_interface_wr_n, external_memory_interface_rd_n, external_memory_interface_ale}))
      else $error("Port 4 not following memory strobes");
   external_memory_interface_rdbus_a: assert property (
      (external_memory_interface_on && external_memory_interface_read && !external_memory_interface_muxed) |=> p7_pin_oe == 8'h00)
      else $error("Data bus driven during off-chip read");
   latch_write_a: assert property (
      (sfr_wr && acc(sfr_page, sfr_addr, hpp_pkg::ADDR_LATCH7))
      |=> port7_output_latch == $past(sfr_wdata))
      else $error("Port 7 latch write lost");
   pin_read_a: assert property (
      (sfr_rd && !sfr_rmw && acc(sfr_page, sfr_addr, hpp_pkg::ADDR_LATCH5))
      |=> sfr_rdata == $past(p5_pin_in, 3))
      else $error("Port 5 read not the synchronised pin level");
   rmw_read_a: assert property (
      (sfr_rd && sfr_rmw && acc(sfr_page, sfr_addr, hpp_pkg::ADDR_LATCH6))
      |=> sfr_rdata == $past(port6_output_latch))
      else $error("Read-modify-write did not return latch");
   p6_addr_a: assert property (
      (external_memory_interface_on && !external_memory_interface_muxed) |=> p6_pin_out == $past(external_memory_interface_addr[7:0]))
      else $error("Port 6 not low address in non-multiplexed mode");

   pp_out_c:   cover property (port5_drive_mode == 8'hFF && !external_memory_interface_on);
   external_memory_interface_rd_c:  cover property (external_memory_interface_on && external_memory_interface_read ##1 external_memory_interface_on);
   rmw_c:      cover property (sfr_rd && sfr_rmw && sfr_hit);
   pu_off_c:   cover property (pullup_global_disable
                               ##1 !pullup_global_disable);
endmodule : hpp_port

// >>> testbench/hpp_far_end.sv
`timescale 1ns/1ps
// Far-side devices sharing the 27 high-port wires (p4 7:5, p5, p6, p7)
module hpp_far_end (
   input  wire logic        core_clk,
   input  wire logic [26:0] pin_out,
   input  wire logic [26:0] pin_oe,
   input  wire logic [26:0] pullup_en,
   input  wire logic [26:0] drv_en,
   input  wire logic [26:0] drv_val,
   output logic      [26:0] pin_level
);
   logic [26:0] float_r = 27'h0000000;

   // A wire nobody holds toggles, so a stale level can never pass a read
   always @(posedge core_clk) begin
      float_r <= ~float_r;
   end

   // Own driver first, then far side, then pull-up; open-drain high hands
   // the wire over to the far side
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & drv_en & drv_val) |
                      (~pin_oe & ~drv_en & (pullup_en | float_r));
endmodule : hpp_far_end

// >>> testbench/test_high_port_pin_control.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin \
 n_errors++; $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); \
 end end
module test_high_port_pin_control;
   logic        core_clk = 1'b0, rstn = 1'b0;
   logic [7:0]  sfr_page = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00;
   logic        sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0, sfr_hit;
   logic        pullup_global_disable = 1'b0, external_memory_interface_en = 1'b0;
   logic        external_memory_interface_active = 1'b0, external_memory_interface_read = 1'b0, external_memory_interface_muxed = 1'b0;
   logic        external_memory_interface_wr_n = 1'b1, external_memory_interface_rd_n = 1'b1, external_memory_interface_ale = 1'b0;
   logic [15:0] external_memory_interface_addr = 16'h0000;
   logic [7:0]  external_memory_interface_wdata = 8'h00, sfr_rdata, rd_v;
   logic [2:0]  p4_pin_in, p4_pin_out, p4_pin_oe, p4_pullup_en;
   logic [7:0]  p5_pin_in, p5_pin_out, p5_pin_oe, p5_pullup_en;
   logic [7:0]  p6_pin_in, p6_pin_out, p6_pin_oe, p6_pullup_en;
   logic [7:0]  p7_pin_in, p7_pin_out, p7_pin_oe, p7_pullup_en;
   logic [26:0] lvl, pout, poe, ppu, mode = 27'h0, drv_en = 27'h0;
   logic [26:0] lat = 27'h7FFFFFF, drv_val = 27'h0;
   integer      n_errors = 0, samples_checked = 0, seed = 32'hB840;

   assign pout = {p4_pin_out, p5_pin_out, p6_pin_out, p7_pin_out};
   assign poe = {p4_pin_oe, p5_pin_oe, p6_pin_oe, p7_pin_oe};
   assign ppu = {p4_pullup_en, p5_pullup_en, p6_pullup_en, p7_pullup_en};
   assign {p4_pin_in, p5_pin_in, p6_pin_in, p7_pin_in} = lvl;

   always #2.5 core_clk = ~core_clk;

   hpp_port dut_u (.core_clk, .rstn, .sfr_page, .sfr_addr, .sfr_wr, .sfr_rd,
      .sfr_rmw, .sfr_wdata, .sfr_rdata, .sfr_hit, .pullup_global_disable,
      .external_memory_interface_en, .external_memory_interface_active, .external_memory_interface_read, .external_memory_interface_muxed, .external_memory_interface_wr_n,
      .external_memory_interface_rd_n, .external_memory_interface_ale, .external_memory_interface_addr, .external_memory_interface_wdata, .p4_pin_in,
      .p4_pin_out, .p4_pin_oe, .p4_pullup_en, .p5_pin_in, .p5_pin_out,
      .p5_pin_oe, .p5_pullup_en, .p6_pin_in, .p6_pin_out, .p6_pin_oe,
      .p6_pullup_en, .p7_pin_in, .p7_pin_out, .p7_pin_oe, .p7_pullup_en);

   hpp_far_end far_u (.core_clk, .pin_out(pout), .pin_oe(poe),
      .pullup_en(ppu), .drv_en, .drv_val, .pin_level(lvl));

   // Port index 0..3 stands for ports 4..7
   function automatic logic [7:0] adr(input int p, input logic m);
      case (p)
         0: return m ? hpp_pkg::ADDR_MODE4 : hpp_pkg::ADDR_LATCH4;
         1: return m ? hpp_pkg::ADDR_MODE5 : hpp_pkg::ADDR_LATCH5;
         2: return m ? hpp_pkg::ADDR_MODE6 : hpp_pkg::ADDR_LATCH6;
         default: return m ? hpp_pkg::ADDR_MODE7 : hpp_pkg::ADDR_LATCH7;
      endcase
   endfunction : adr

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge core_clk);
      sfr_wr = 1'b0;
   endtask : reg_wr

   // Extra cycle before sampling; read data holds until the next read
   task automatic rd(input logic [7:0] a, input logic r);
      @(negedge core_clk);
      sfr_addr = a;
      sfr_rmw = r;
      sfr_rd = 1'b1;
      @(negedge core_clk);
      sfr_rd = 1'b0;
      sfr_rmw = 1'b0;
      @(negedge core_clk);
      rd_v = sfr_rdata;
   endtask : rd

   // Write a register and mirror it in the model
   task automatic put(input int p, input logic m, input logic [7:0] v);
      reg_wr(adr(p, m), (p == 0 && !m) ? (v | 8'h1F) : v);
      if (p == 0 && m) mode[26:24] = v[7:5];
      else if (p == 0) lat[26:24] = v[7:5];
      else if (m) mode[(3 - p) * 8 +: 8] = v;
      else lat[(3 - p) * 8 +: 8] = v;
   endtask : put

   // Expected pad controls from latches, modes and memory interface
   task automatic chk_pins;
      logic [26:0] eo, eoe, epu;
      logic        em;
      em = external_memory_interface_en & external_memory_interface_active;
      eo = lat;
      if (em) begin
         eo[26:24] = {external_memory_interface_wr_n, external_memory_interface_rd_n, external_memory_interface_ale};
         if (!external_memory_interface_muxed) eo[23:16] = external_memory_interface_addr[15:8];
         eo[15:8] = external_memory_interface_muxed ? external_memory_interface_addr[15:8] : external_memory_interface_addr[7:0];
         eo[7:0] = (external_memory_interface_muxed & external_memory_interface_ale) ? external_memory_interface_addr[7:0] : external_memory_interface_wdata;
      end
      eoe = mode | ~eo;
      if (em & external_memory_interface_read & ~(external_memory_interface_muxed & external_memory_interface_ale)) eoe[7:0] = 8'h00;
      epu = pullup_global_disable ? 27'h0 : ~(eoe & ~eo);
      `CHK("pin_oe", eoe, poe)
      `CHK("pin_out", eo | ~eoe, pout | ~poe)
      `CHK("pullup_en", epu, ppu)
   endtask : chk_pins

   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   // Watchdog, far beyond the roughly 1420 ns the sequence needs
   initial begin
      #20000;
      n_errors++;
      close_out;
   end

   initial begin
      repeat (12) @(negedge core_clk);
      rstn = 1'b1;
      sfr_page = hpp_pkg::PAGE_HIGH;
      @(negedge core_clk);
      chk_pins;
      for (int p = 0; p < 4; p++) begin
         rd(adr(p, 1'b1), 1'b0);
         `CHK("mode_rst", hpp_pkg::MODE_RST, rd_v)
      end
      // Random latches, modes and pull-up disable
      for (int i = 0; i < 8; i++) begin
         for (int p = 0; p < 4; p++) begin
            put(p, 1'b0, 8'($random(seed)));
            put(p, 1'b1, 8'($random(seed)));
         end
         pullup_global_disable = i[0];
         repeat (2) @(negedge core_clk);
         chk_pins;
         rd(adr(1, 1'b1), 1'b0);
         `CHK("mode5", mode[23:16], rd_v)
         rd(adr(0, 1'b0), 1'b1);
         `CHK("latch4_rmw", {lat[26:24], 5'h1F}, rd_v)
      end
      // Digital inputs driven by the far side
      for (int p = 0; p < 4; p++) begin
         put(p, 1'b0, 8'hFF);
         put(p, 1'b1, 8'h00);
      end
      drv_en = 27'h7FFFFFF;
      drv_val = 27'($random(seed));
      repeat (4) @(negedge core_clk);
      rd(adr(1, 1'b0), 1'b0);
      `CHK("pin5", drv_val[23:16], rd_v)
      rd(adr(0, 1'b0), 1'b0);
      `CHK("pin4", {drv_val[26:24], 5'h1F}, rd_v)
      rd(adr(3, 1'b0), 1'b1);
      `CHK("latch7_rmw", 8'hFF, rd_v)
      rd(adr(2, 1'b0), 1'b1);
      `CHK("latch6_rmw", 8'hFF, rd_v)
      drv_en = 27'h0;
      pullup_global_disable = 1'b0;
      repeat (4) @(negedge core_clk);
      rd(adr(2, 1'b0), 1'b0);
      `CHK("pin6_pulled", 8'hFF, rd_v)
      // Other register page is not decoded
      sfr_page = 8'h00;
      sfr_addr = hpp_pkg::ADDR_MODE5;
      #1 `CHK("hit_off", 1'b0, sfr_hit)
      reg_wr(hpp_pkg::ADDR_MODE5, 8'hFF);
      rd(hpp_pkg::ADDR_MODE5, 1'b0);
      `CHK("off_page", 8'h00, rd_v)
      sfr_page = hpp_pkg::PAGE_HIGH;
      #1 `CHK("hit_on", 1'b1, sfr_hit)
      rd(hpp_pkg::ADDR_MODE5, 1'b0);
      `CHK("mode5_kept", mode[23:16], rd_v)
      // Memory interface takes the pins; last pass ends the access
      put(3, 1'b1, 8'hF0);
      external_memory_interface_en = 1'b1;
      for (int k = 0; k < 9; k++) begin
         external_memory_interface_active = (k < 8);
         {external_memory_interface_muxed, external_memory_interface_read, external_memory_interface_ale} = 3'(k);
         external_memory_interface_wr_n = external_memory_interface_read;
         external_memory_interface_rd_n = ~external_memory_interface_read;
         external_memory_interface_addr = 16'($random(seed));
         external_memory_interface_wdata = 8'($random(seed));
         repeat (2) @(negedge core_clk);
         chk_pins;
      end
      close_out;
   end
endmodule : test_high_port_pin_control
